// ===== csp_consts.svh
// Named constants for the configuration status and suspend block.
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH
`define CSP_IR_W       4
`define CSP_DR_W       8
`define CSP_IR_BYPASS  4'hf
`define CSP_IR_STATUS  4'h2
`define CSP_IR_CAPTURE 4'h1
`define CSP_IR_RESET   4'hf
`define CSP_DR_PAD     5'h00
`define CSP_BIT_CLR    1'b0
`define CSP_BIT_SET    1'b1
`endif

// ===== csp_pkg.sv
// Types shared by the configuration status and suspend block.
package csp_pkg;
  // Boundary-scan pins sampled on the system clock.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } csp_scan_s;
  // Status bits shown through the scan status register.
  typedef struct packed {
    logic done;
    logic error;
    logic req;
  } csp_status_s;
  // Suspend handshake states, Gray coded along idle, request, suspended.
  typedef enum logic [1:0] {
    SUS_IDLE = 2'h0,
    SUS_REQ  = 2'h1,
    SUS_SUSP = 2'h3
  } csp_sus_e;
  // Scan controller states.
  typedef enum logic [3:0] {
    TAP_RESET  = 4'h0,
    TAP_IDLE   = 4'h1,
    TAP_SELDR  = 4'h3,
    TAP_CAPDR  = 4'h2,
    TAP_SHDR   = 4'h6,
    TAP_EX1DR  = 4'h7,
    TAP_PADR   = 4'h5,
    TAP_EX2DR  = 4'h4,
    TAP_UPDR   = 4'hc,
    TAP_SELIR  = 4'hd,
    TAP_CAPIR  = 4'hf,
    TAP_SHIR   = 4'he,
    TAP_EX1IR  = 4'ha,
    TAP_PAIR   = 4'hb,
    TAP_EX2IR  = 4'h9,
    TAP_UPIR   = 4'h8
  } csp_tap_e;
endpackage

// ===== csp_top.sv
// Configuration status, suspend handshake and scan port logic.
`timescale 1ns/1ps
`include "csp_consts.svh"

//Contract
// R01: Suspend pin raises request toward user logic.
// R02: User logic acknowledges only when ready.
// R03: Acknowledge sampled on user handshake clock.
// R04: Error flag high when integrity check fails.
// R05: Done reads zero unconfigured, one configured.
// R06: Full-chip reset low resets asynchronously.
// R07: Full-chip reset leaves scan controller alone.
// R08: TDI captured on rising TCK.
// R09: TDO changes on falling TCK, shift-only.
// R10: TMS sampled on rising TCK.
// R11: Dedicated pins keep configuration function.
// R12: Suspend pin held low during configuration.
// R13: Enter suspend only after sampled acknowledge.
module csp_top #(
  parameter int IR_W = `CSP_IR_W,
  parameter int DR_W = `CSP_DR_W
) (
  input  wire logic ref_clk_in,          // System clock, 25 MHz.
  input  wire logic rstn_in,             // Synchronous reset, low.
  input  wire logic program_n_in,        // Full-chip reset, async low.
  input  wire logic suspend_pin_in,      // Suspend pin level.
  input  wire logic user_hs_clk_in,      // User handshake clock.
  input  wire logic suspend_ack_in,      // User acknowledge.
  input  wire logic config_load_done_in, // Loader finished, pulse.
  input  wire logic integrity_err_in,    // Integrity check failing.
  input  wire logic tck_in,              // Scan clock pin.
  input  wire logic tms_in,              // Scan mode select pin.
  input  wire logic tdi_in,              // Scan data in pin.
  output logic      suspend_request_out, // Request to user logic.
  output logic      suspend_entry_out,   // Device enters suspend.
  output logic      post_config_error_flag_out, // Integrity error.
  output logic      config_done_out,     // Configuration complete.
  output logic      cfg_pin_dedicated_out, // Pins stay dedicated.
  output logic      tdo_out,             // Scan data out.
  output logic      tdo_oe_out           // Scan data out enable.
);

  // The shift register must hold the status word and the pad field, so
  // other widths are refused while the design is elaborated.
  if (IR_W != `CSP_IR_W || DR_W != `CSP_DR_W) begin
    $error("csp_top: unsupported register widths");
  end

  csp_pkg::csp_scan_s   pins;
  csp_pkg::csp_scan_s   pins_q;
  csp_pkg::csp_status_s stat;
  csp_pkg::csp_sus_e    sus_state;
  csp_pkg::csp_tap_e    tap_state;
  csp_pkg::csp_tap_e    next_tap_state;
  logic                 hs_clk_q;
  logic                 hs_rise;
  logic                 tck_rise;
  logic                 tck_fall;
  logic [IR_W-1:0]      ir_shift;
  logic [IR_W-1:0]      ir;
  logic [DR_W-1:0]      dr_shift;
  logic                 bypass_bit;
  logic                 shift_out;

  // Scan controller transition for one rising scan clock edge.
  function automatic csp_pkg::csp_tap_e tap_step(
    input csp_pkg::csp_tap_e st,
    input logic              tms
  );
    case (st)
      csp_pkg::TAP_RESET: begin
        tap_step = tms ? csp_pkg::TAP_RESET : csp_pkg::TAP_IDLE;
      end
      csp_pkg::TAP_IDLE: begin
        tap_step = tms ? csp_pkg::TAP_SELDR : csp_pkg::TAP_IDLE;
      end
      csp_pkg::TAP_SELDR: begin
        tap_step = tms ? csp_pkg::TAP_SELIR : csp_pkg::TAP_CAPDR;
      end
      csp_pkg::TAP_CAPDR: begin
        tap_step = tms ? csp_pkg::TAP_EX1DR : csp_pkg::TAP_SHDR;
      end
      csp_pkg::TAP_SHDR: begin
        tap_step = tms ? csp_pkg::TAP_EX1DR : csp_pkg::TAP_SHDR;
      end
      csp_pkg::TAP_EX1DR: begin
        tap_step = tms ? csp_pkg::TAP_UPDR : csp_pkg::TAP_PADR;
      end
      csp_pkg::TAP_PADR: begin
        tap_step = tms ? csp_pkg::TAP_EX2DR : csp_pkg::TAP_PADR;
      end
      csp_pkg::TAP_EX2DR: begin
        tap_step = tms ? csp_pkg::TAP_UPDR : csp_pkg::TAP_SHDR;
      end
      csp_pkg::TAP_UPDR: begin
        tap_step = tms ? csp_pkg::TAP_SELDR : csp_pkg::TAP_IDLE;
      end
      csp_pkg::TAP_SELIR: begin
        tap_step = tms ? csp_pkg::TAP_RESET : csp_pkg::TAP_CAPIR;
      end
      csp_pkg::TAP_CAPIR: begin
        tap_step = tms ? csp_pkg::TAP_EX1IR : csp_pkg::TAP_SHIR;
      end
      csp_pkg::TAP_SHIR: begin
        tap_step = tms ? csp_pkg::TAP_EX1IR : csp_pkg::TAP_SHIR;
      end
      csp_pkg::TAP_EX1IR: begin
        tap_step = tms ? csp_pkg::TAP_UPIR : csp_pkg::TAP_PAIR;
      end
      csp_pkg::TAP_PAIR: begin
        tap_step = tms ? csp_pkg::TAP_EX2IR : csp_pkg::TAP_PAIR;
      end
      csp_pkg::TAP_EX2IR: begin
        tap_step = tms ? csp_pkg::TAP_UPIR : csp_pkg::TAP_SHIR;
      end
      csp_pkg::TAP_UPIR: begin
        tap_step = tms ? csp_pkg::TAP_SELDR : csp_pkg::TAP_IDLE;
      end
      default: begin
        tap_step = csp_pkg::TAP_RESET;
      end
    endcase
  endfunction

  // Pins are already synchronous; one stage gives edge detection.
  assign pins.tck = tck_in;
  assign pins.tms = tms_in;
  assign pins.tdi = tdi_in;
  assign tck_rise = pins.tck & ~pins_q.tck;
  assign tck_fall = ~pins.tck & pins_q.tck;
  assign hs_rise  = user_hs_clk_in & ~hs_clk_q;

  // Scan pin and handshake clock history, kept on the system reset only.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      pins_q   <= '0;
      hs_clk_q <= `CSP_BIT_CLR;
    end else begin
      pins_q   <= pins;
      hs_clk_q <= user_hs_clk_in;
    end
  end

  // R10: TMS steps controller.
  // The full-chip reset is deliberately absent here.
  // R07: controller ignores full-chip reset.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      tap_state <= csp_pkg::TAP_RESET;
    end else if (tck_rise) begin
      tap_state <= next_tap_state;
    end
  end
  assign next_tap_state = tap_step(tap_state, pins.tms);

  // R08: TDI into instruction register.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      ir_shift <= `CSP_IR_RESET;
      ir       <= `CSP_IR_RESET;
    end else if (tap_state == csp_pkg::TAP_RESET) begin
      ir <= `CSP_IR_RESET;
    end else if (tck_rise) begin
      case (tap_state)
        csp_pkg::TAP_CAPIR: begin
          ir_shift <= `CSP_IR_CAPTURE;
        end
        csp_pkg::TAP_SHIR: begin
          ir_shift <= {pins.tdi, ir_shift[IR_W-1:1]};
        end
        csp_pkg::TAP_UPIR: begin
          ir <= ir_shift;
        end
        default: begin
          ir_shift <= ir_shift;
        end
      endcase
    end
  end

  // R08: TDI into data registers.
  // The status word is captured so a tester can watch the block.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      dr_shift   <= '0;
      bypass_bit <= `CSP_BIT_CLR;
    end else if (tck_rise) begin
      case (tap_state)
        csp_pkg::TAP_CAPDR: begin
          dr_shift   <= {`CSP_DR_PAD, stat};
          bypass_bit <= `CSP_BIT_CLR;
        end
        csp_pkg::TAP_SHDR: begin
          dr_shift   <= {pins.tdi, dr_shift[DR_W-1:1]};
          bypass_bit <= pins.tdi;
        end
        default: begin
          bypass_bit <= bypass_bit;
        end
      endcase
    end
  end

  // Pick the serial source for the present instruction and state.
  always_comb begin
    if (tap_state == csp_pkg::TAP_SHIR) begin
      shift_out = ir_shift[0];
    end else if (ir == `CSP_IR_STATUS) begin
      shift_out = dr_shift[0];
    end else begin
      shift_out = bypass_bit;
    end
  end

  // R09: TDO on falling TCK.
  // Driving only while shifting leaves the line free for other parts.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      tdo_out    <= `CSP_BIT_CLR;
      tdo_oe_out <= `CSP_BIT_CLR;
    end else if (tck_fall) begin
      tdo_out    <= shift_out;
      tdo_oe_out <= (tap_state == csp_pkg::TAP_SHIR) |
                    (tap_state == csp_pkg::TAP_SHDR);
    end
  end

  // R05: done flag after load.
  // R06: asynchronous full-chip reset.
  always_ff @(posedge ref_clk_in or negedge program_n_in) begin
    if (!program_n_in) begin
      config_done_out <= `CSP_BIT_CLR;
    end else if (!rstn_in) begin
      config_done_out <= `CSP_BIT_CLR;
    end else if (config_load_done_in) begin
      config_done_out <= `CSP_BIT_SET;
    end
  end

  // R04: error follows integrity check.
  // The check only has meaning once the device is configured.
  always_ff @(posedge ref_clk_in or negedge program_n_in) begin
    if (!program_n_in) begin
      post_config_error_flag_out <= `CSP_BIT_CLR;
    end else if (!rstn_in) begin
      post_config_error_flag_out <= `CSP_BIT_CLR;
    end else begin
      post_config_error_flag_out <= config_done_out & integrity_err_in;
    end
  end

  // R11: pins stay dedicated.
  // There is no release path, so nothing can hand them to user logic.
  always_ff @(posedge ref_clk_in or negedge program_n_in) begin
    if (!program_n_in) begin
      cfg_pin_dedicated_out <= `CSP_BIT_SET;
    end else begin
      cfg_pin_dedicated_out <= `CSP_BIT_SET;
    end
  end

  // R01: request from suspend pin.
  // R13: enter only after acknowledge.
  // R03: ack sampled on handshake clock.
  // The request is only honoured once configured, which also keeps a
  // pin left high through power-up from stalling configuration.
  always_ff @(posedge ref_clk_in or negedge program_n_in) begin
    if (!program_n_in) begin
      sus_state <= csp_pkg::SUS_IDLE;
    end else if (!rstn_in) begin
      sus_state <= csp_pkg::SUS_IDLE;
    end else begin
      case (sus_state)
        csp_pkg::SUS_IDLE: begin
          if (suspend_pin_in && config_done_out) begin
            sus_state <= csp_pkg::SUS_REQ;
          end
        end
        csp_pkg::SUS_REQ: begin
          if (!suspend_pin_in) begin
            sus_state <= csp_pkg::SUS_IDLE;
          end else if (hs_rise && suspend_ack_in) begin
            sus_state <= csp_pkg::SUS_SUSP;
          end
        end
        csp_pkg::SUS_SUSP: begin
          if (!suspend_pin_in) begin
            sus_state <= csp_pkg::SUS_IDLE;
          end
        end
        default: begin
          sus_state <= csp_pkg::SUS_IDLE;
        end
      endcase
    end
  end

  // Outputs registered from the state so they come from flip-flops.
  always_ff @(posedge ref_clk_in or negedge program_n_in) begin
    if (!program_n_in) begin
      suspend_request_out <= `CSP_BIT_CLR;
      suspend_entry_out   <= `CSP_BIT_CLR;
    end else if (!rstn_in) begin
      suspend_request_out <= `CSP_BIT_CLR;
      suspend_entry_out   <= `CSP_BIT_CLR;
    end else begin
      suspend_request_out <= (sus_state != csp_pkg::SUS_IDLE);
      suspend_entry_out   <= (sus_state == csp_pkg::SUS_SUSP);
    end
  end

  // Status visible through the scan status register.
  assign stat.done  = config_done_out;
  assign stat.error = post_config_error_flag_out;
  assign stat.req   = suspend_request_out;

endmodule

// ===== csp_checker.sv
// Checker for the status, suspend and scan ports of the block.
`timescale 1ns/1ps
module csp_checker (
  input wire logic ref_clk_in,                 // Clock.
  input wire logic rstn_in,                    // Reset.
  input wire logic program_n_in,               // Full reset.
  input wire logic suspend_pin_in,             // Pin.
  input wire logic user_hs_clk_in,             // Hs clock.
  input wire logic suspend_ack_in,             // Ack.
  input wire logic config_load_done_in,        // Loaded.
  input wire logic integrity_err_in,           // Check fail.
  input wire logic tck_in,                     // Scan clock.
  input wire logic tms_in,                     // Mode.
  input wire logic tdi_in,                     // Data in.
  input wire logic suspend_request_out,        // Request.
  input wire logic suspend_entry_out,          // Entry.
  input wire logic post_config_error_flag_out, // Error.
  input wire logic config_done_out,            // Done.
  input wire logic cfg_pin_dedicated_out,      // Dedicated.
  input wire logic tdo_out,                    // Data out.
  input wire logic tdo_oe_out                  // Enable.
);
  logic hs_q;
  logic acked;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // An ack counts only on a handshake clock rise while requesting.
  always_ff @(posedge ref_clk_in) begin
    hs_q <= user_hs_clk_in;
    if (!rstn_in || !suspend_request_out) begin
      acked <= 1'b0;
    end else if (user_hs_clk_in && !hs_q && suspend_ack_in) begin
      acked <= 1'b1;
    end
  end
  // Timing relations between causes and the outputs.
  req_rise_a: assert property ((suspend_pin_in && config_done_out
    && program_n_in)[*3] |=> suspend_request_out || !program_n_in)
    else $error("request did not follow the pin");
  entry_ack_a: assert property (suspend_entry_out |-> acked
    && suspend_request_out) else $error("entry without ack");
  err_flag_a: assert property (config_done_out && integrity_err_in
    && program_n_in |=> post_config_error_flag_out || !program_n_in)
    else $error("error flag missing");
  err_mask_a: assert property (!(config_done_out && integrity_err_in)
    |=> !post_config_error_flag_out) else $error("false error flag");
  done_hold_a: assert property (config_done_out && program_n_in
    |=> config_done_out || !program_n_in) else $error("done lost");
  prog_clear_a: assert property (!program_n_in |-> !config_done_out
    && !suspend_request_out && !suspend_entry_out
    && !post_config_error_flag_out) else $error("full reset ignored");
  pins_kept_a: assert property (cfg_pin_dedicated_out)
    else $error("pins left dedicated use");
  tdo_fall_a: assert property (!$stable({tdo_out, tdo_oe_out})
    |-> !$past(tck_in) && $past(tck_in, 2)) else $error("tdo off fall");
  cover property (suspend_entry_out);
  cover property (post_config_error_flag_out);
  cover property (tdo_oe_out);
endmodule
bind csp_top csp_checker u_chk (.*);

// ===== csp_user_model.sv
// User fabric model answering the suspend request.
`timescale 1ns/1ps
module csp_user_model (
  input  wire logic       req_in,     // Request seen.
  input  wire logic [3:0] wait_in,    // Edges before ready.
  output logic            hs_clk_out, // Handshake clock.
  output logic            ack_out     // Ready.
);
  int n;
  // The user clock runs free with a phase unrelated to the system one.
  initial begin
    hs_clk_out = 1'b0;
    ack_out = 1'b0;
    n = 0;
    #7;
    forever #60 hs_clk_out = ~hs_clk_out;
  end
  always @(negedge hs_clk_out) begin
    if (!req_in) begin
      n = 0;
      ack_out <= 1'b0;
    end else if (n >= int'(wait_in)) begin
      ack_out <= 1'b1;
    end else begin
      n = n + 1;
    end
  end
endmodule

// ===== csp_top_tb_top.sv
// Self-checking bench for the status, suspend and scan block.
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_top_tb_top;
  logic ref_clk_in, rstn_in, program_n_in, suspend_pin_in;
  logic user_hs_clk_in, suspend_ack_in, config_load_done_in;
  logic integrity_err_in, tck_in, tms_in, tdi_in;
  logic suspend_request_out, suspend_entry_out, config_done_out;
  logic post_config_error_flag_out, cfg_pin_dedicated_out;
  logic tdo_out, tdo_oe_out;
  logic [3:0] wait_q;
  int         bad_count;
  int         checks_done;
  int         cycles;
  csp_top DUT (.*);
  csp_user_model u_user (.req_in(suspend_request_out), .wait_in(wait_q),
    .hs_clk_out(user_hs_clk_in), .ack_out(suspend_ack_in));
  // Free-running system clock.
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles > 5000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Each scan clock phase lasts two system cycles.
  task automatic tck_step(input logic tms, input logic tdi, output logic tdo);
    tms_in = tms;
    tdi_in = tdi;
    tck_in = 1'b1;
    cyc(2);
    tck_in = 1'b0;
    cyc(2);
    tdo = tdo_out;
  endtask
  // From idle, shift n bits through the instruction or data path.
  task automatic scan(input logic ir, input int n, input logic [7:0] din,
                      output logic [7:0] dout);
    logic b;
    dout = 8'h00;
    tck_step(1'b1, 1'b0, b);
    if (ir) tck_step(1'b1, 1'b0, b);
    tck_step(1'b0, 1'b0, b);
    tck_step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      dout[i] = b;
      check("oe shift", 8'(tdo_oe_out), 8'h01);
      tck_step(i == n - 1, din[i], b);
    end
    check("oe exit", 8'(tdo_oe_out), 8'h00);
    tck_step(1'b1, 1'b0, b);
    tck_step(1'b0, 1'b0, b);
  endtask
  task automatic t_reset();
    check("done rst", 8'(config_done_out), 8'h00);
    check("pins", 8'(cfg_pin_dedicated_out), 8'h01);
    check("oe rst", 8'(tdo_oe_out), 8'h00);
  endtask
  task automatic t_config();
    integrity_err_in = 1'b1;
    cyc(3);
    check("err masked", 8'(post_config_error_flag_out), 8'h00);
    config_load_done_in = 1'b1;
    cyc(1);
    config_load_done_in = 1'b0;
    cyc(2);
    check("done set", 8'(config_done_out), 8'h01);
    check("err set", 8'(post_config_error_flag_out), 8'h01);
    integrity_err_in = 1'b0;
    cyc(2);
    check("err clr", 8'(post_config_error_flag_out), 8'h00);
  endtask
  // A pin dropped before the user is ready must never reach suspend.
  task automatic t_abort();
    wait_q = 4'hf;
    suspend_pin_in = 1'b1;
    cyc(3);
    check("abort req", 8'(suspend_request_out), 8'h01);
    suspend_pin_in = 1'b0;
    cyc(3);
    check("abort req off", 8'(suspend_request_out), 8'h00);
    check("abort no entry", 8'(suspend_entry_out), 8'h00);
  endtask
  task automatic t_suspend(input logic [3:0] w);
    wait_q = w;
    suspend_pin_in = 1'b1;
    cyc(3);
    check("req", 8'(suspend_request_out), 8'h01);
    check("no entry", 8'(suspend_entry_out), 8'h00);
    for (int i = 0; i < 100 && suspend_entry_out !== 1'b1; i++) cyc(1);
    check("entry", 8'(suspend_entry_out), 8'h01);
    suspend_pin_in = 1'b0;
    cyc(3);
    check("req off", 8'(suspend_request_out), 8'h00);
    check("entry off", 8'(suspend_entry_out), 8'h00);
  endtask
  task automatic t_scan();
    logic [7:0] d;
    logic       b;
    integrity_err_in = 1'b1;
    tck_step(1'b0, 1'b0, b);
    scan(1'b1, 4, {4'h0, `CSP_IR_STATUS}, d);
    check("ir capture", d, {4'h0, `CSP_IR_CAPTURE});
    scan(1'b0, 8, 8'hff, d);
    check("status", d, 8'h06);
    program_n_in = 1'b0;
    #1;
    check("done prog", 8'(config_done_out), 8'h00);
    cyc(1);
    program_n_in = 1'b1;
    cyc(1);
    scan(1'b0, 8, 8'hff, d);
    check("scan kept", d, 8'h00);
    repeat (5) tck_step(1'b1, 1'b0, b);
    tck_step(1'b0, 1'b0, b);
    scan(1'b0, 2, 8'hff, d);
    check("bypass", d, 8'h02);
  endtask
  initial begin
    {rstn_in, suspend_pin_in, config_load_done_in} = 3'h0;
    {integrity_err_in, tck_in, tms_in, tdi_in} = 4'h0;
    program_n_in = 1'b1;
    wait_q = 4'h3;
    repeat (4) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    cyc(1);
    t_reset();
    t_config();
    t_abort();
    t_suspend(4'h3);
    t_suspend(4'h0);
    t_scan();
    test_done();
  end
endmodule
